// ==== hdl/itsf_status.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "itsf_regs.svh"

// Summary of operation
// - rx full set on move, cleared by read
// - read keeps rx full while byte waits
// - target stop flag; clear: status0 read, ctl0 write
// - header10 flag; clear: status0 read, data write
// - byte done when stretching and buffer stalls
// - byte done cleared: status0 read, data access
// - byte done cleared by own start, own stop, disable
// - address flag on ack or own match
// - address flag cleared: status0 read, status1 read
// - start flag; clear: status0 read, data write
// - check byte shown in status1 15:8
// - dual flag tells which own address matched
// - status1 address-kind and direction flags cleared by start, stop, disable
// - host header flag set on reception
// - default address flag set on reception
// - general call flag set on address zero
// - direction flag, cleared on lost arbitration
// - busy while bus active, cleared by stop
// - controller flag set by start, cleared by stop, disable or lost arbitration
// - tx empty set on move, cleared by write
module itsf_status (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	// register port
	input wire itsf_pkg::itsf_bus_req_t bus_req,
	output logic [31:0] rd_data,
	// bus engine side
	input wire itsf_pkg::itsf_event_t bus_ev,
	output logic [7:0] tx_byte,
	output logic tx_buffer_empty,
	output logic stretch_hold,
	output logic peripheral_enable
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	logic [`ITSF_CTL0_W-1:0] ctl0_reg;
	logic stat0_seen_reg;
	logic rx_buffer_full, rx_pend_reg;
	logic [7:0] rx_data_reg, rx_shift_reg;
	logic [7:0] tx_data_reg;
	logic byte_done_flag, stop_seen_flag, header10_sent_flag;
	logic address_flag, start_sent_flag;
	logic dual_match_flag, host_header_flag, default_addr_flag, general_call_flag;
	logic sending_role_flag, bus_busy_flag, controller_flag;
	logic [31:0] rd_data_reg, rd_data_next;
	logic en, stretch_en, pec_en, dual_en;
	logic rd_s0, rd_s1, rd_dat, wr_dat, wr_ctl0;
	logic hw_clr, s1_clr;
	logic [31:0] stat0_word, stat1_word;
	assign en = ctl0_reg[`ITSF_CTL0_EN];
	assign pec_en = ctl0_reg[`ITSF_CTL0_PECEN];
	assign stretch_en = ctl0_reg[`ITSF_CTL0_STRETCH];
	assign dual_en = ctl0_reg[`ITSF_CTL0_DUALEN];

	assign rd_s0 = ce && bus_req.rd && hit(bus_req.addr, `ITSF_STAT0_OFF);
	assign rd_s1 = ce && bus_req.rd && hit(bus_req.addr, `ITSF_STAT1_OFF);
	assign rd_dat = ce && bus_req.rd && hit(bus_req.addr, `ITSF_DATA_OFF);
	assign wr_dat = ce && bus_req.wr && hit(bus_req.addr, `ITSF_DATA_OFF);
	assign wr_ctl0 = ce && bus_req.wr && hit(bus_req.addr, `ITSF_CTL0_OFF);
	// own start or stop also shows on the bus; hw_clr takes own events only, s1_clr catches both sources
	assign hw_clr = bus_ev.start_sent || bus_ev.stop_sent || !en;
	assign s1_clr = hw_clr || bus_ev.start_seen || bus_ev.stop_seen;
	// control register
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			ctl0_reg <= `ITSF_CTL0_RST;
		else if (wr_ctl0)
			ctl0_reg <= bus_req.wdata[`ITSF_CTL0_W-1:0];
	end
	// a data access, status1 read or ctl0 write ends the sequence, so a stale read cannot clear later
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			stat0_seen_reg <= 1'b0;
		else if (ce)
		begin
			if (rd_s0)
				stat0_seen_reg <= 1'b1;
			else if (rd_dat || wr_dat || rd_s1 || wr_ctl0)
				stat0_seen_reg <= 1'b0;
		end
	end
	// receive path: data register plus one byte held in the shifter
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			rx_buffer_full <= 1'b0;
			rx_pend_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			rx_shift_reg <= 8'h00;
		end
		else if (ce)
		begin
			if (!en)
			begin
				rx_buffer_full <= 1'b0;
				rx_pend_reg <= 1'b0;
			end
			else
			begin
				if (rd_dat && rx_buffer_full)
				begin
					if (rx_pend_reg)
					begin
						rx_data_reg <= rx_shift_reg;
						rx_pend_reg <= 1'b0;
					end
					else
						rx_buffer_full <= 1'b0;
				end
				if (bus_ev.rx_valid)
				begin
					if (!rx_buffer_full || (rd_dat && !rx_pend_reg))
					begin
						rx_data_reg <= bus_ev.rx_byte;
						rx_buffer_full <= 1'b1;
					end
					else if (stretch_en)
					begin
						// without stretching the engine flags overrun; byte is lost here
						rx_shift_reg <= bus_ev.rx_byte;
						rx_pend_reg <= 1'b1;
					end
				end
			end
		end
	end
	// transmit data register
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			tx_data_reg <= 8'h00;
			tx_buffer_empty <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_dat)
			begin
				tx_data_reg <= bus_req.wdata[7:0];
				tx_buffer_empty <= 1'b0;
			end
			if (bus_ev.tx_take)
				tx_buffer_empty <= 1'b1;
		end
	end
	// byte done: set wins over every clear
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			byte_done_flag <= 1'b0;
		else if (ce)
		begin
			if (stretch_en && en && ((bus_ev.rx_valid && rx_buffer_full) ||
				(bus_ev.tx_sent && tx_buffer_empty && !sending_role_flag == 1'b0)))
				byte_done_flag <= 1'b1;
			else if (stat0_seen_reg && (rd_dat || wr_dat))
				byte_done_flag <= 1'b0;
			else if (hw_clr)
				byte_done_flag <= 1'b0;
		end
	end
	// stop seen as target
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			stop_seen_flag <= 1'b0;
		else if (ce)
		begin
			if (bus_ev.stop_seen && !controller_flag)
				stop_seen_flag <= 1'b1;
			else if (stat0_seen_reg && wr_ctl0)
				stop_seen_flag <= 1'b0;
		end
	end
	// controller-side start and header flags
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			header10_sent_flag <= 1'b0;
			start_sent_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (bus_ev.header10_sent && controller_flag)
				header10_sent_flag <= 1'b1;
			else if (stat0_seen_reg && wr_dat)
				header10_sent_flag <= 1'b0;
			if (bus_ev.start_sent)
				start_sent_flag <= 1'b1;
			else if (stat0_seen_reg && wr_dat)
				start_sent_flag <= 1'b0;
		end
	end
	// address flag
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			address_flag <= 1'b0;
		else if (ce)
		begin
			if ((controller_flag && bus_ev.addr_acked) ||
				(!controller_flag && bus_ev.addr_match))
				address_flag <= 1'b1;
			else if (stat0_seen_reg && rd_s1)
				address_flag <= 1'b0;
		end
	end
	// target address-kind flags of status 1
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			dual_match_flag <= 1'b0;
			host_header_flag <= 1'b0;
			default_addr_flag <= 1'b0;
			general_call_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (s1_clr)
			begin
				dual_match_flag <= 1'b0;
				host_header_flag <= 1'b0;
				default_addr_flag <= 1'b0;
				general_call_flag <= 1'b0;
			end
			if (bus_ev.addr_match && dual_en)
				dual_match_flag <= bus_ev.match_second;
			if (bus_ev.host_header && !controller_flag)
				host_header_flag <= 1'b1;
			if (bus_ev.default_addr)
				default_addr_flag <= 1'b1;
			if (bus_ev.general_call)
				general_call_flag <= 1'b1;
		end
	end
	// direction, busy and role
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			sending_role_flag <= 1'b0;
			bus_busy_flag <= 1'b0;
			controller_flag <= 1'b0;
		end
		else if (ce)
		begin
			if (s1_clr || bus_ev.arb_lost)
				sending_role_flag <= 1'b0;
			if (bus_ev.dir_update)
				sending_role_flag <= bus_ev.dir_tx;
			if (bus_ev.stop_seen || bus_ev.stop_sent)
				bus_busy_flag <= 1'b0;
			if (bus_ev.start_seen || bus_ev.start_sent)
				bus_busy_flag <= 1'b1;
			if (bus_ev.stop_seen || bus_ev.stop_sent || !en || bus_ev.arb_lost)
				controller_flag <= 1'b0;
			if (bus_ev.start_sent && en)
				controller_flag <= 1'b1;
		end
	end
	// status words
	always_comb
	begin
		stat0_word = `ITSF_STAT0_RST;
		stat0_word[`ITSF_S0_START] = start_sent_flag;
		stat0_word[`ITSF_S0_ADDR] = address_flag;
		stat0_word[`ITSF_S0_BTC] = byte_done_flag;
		stat0_word[`ITSF_S0_H10] = header10_sent_flag;
		stat0_word[`ITSF_S0_STOP] = stop_seen_flag;
		stat0_word[`ITSF_S0_RXFULL] = rx_buffer_full;
		stat0_word[`ITSF_S0_TXEMPTY] = tx_buffer_empty;
	end
	always_comb
	begin
		stat1_word = `ITSF_STAT1_RST;
		stat1_word[`ITSF_S1_MASTER] = controller_flag;
		stat1_word[`ITSF_S1_BUSY] = bus_busy_flag;
		stat1_word[`ITSF_S1_TX] = sending_role_flag;
		stat1_word[`ITSF_S1_GC] = general_call_flag;
		stat1_word[`ITSF_S1_DEF] = default_addr_flag;
		stat1_word[`ITSF_S1_HOST] = host_header_flag;
		stat1_word[`ITSF_S1_DUAL] = dual_match_flag;
		if (pec_en)
			stat1_word[`ITSF_S1_PEC_MSB:`ITSF_S1_PEC_LSB] = bus_ev.check_byte;
	end
	// read mux; unmapped addresses read zero
	always_comb
	begin
		rd_data_next = 32'h0000_0000;
		if (hit(bus_req.addr, `ITSF_CTL0_OFF))
			rd_data_next = {28'h000_0000, ctl0_reg};
		else if (hit(bus_req.addr, `ITSF_DATA_OFF))
			rd_data_next = {24'h00_0000, rx_data_reg};
		else if (hit(bus_req.addr, `ITSF_STAT0_OFF))
			rd_data_next = stat0_word;
		else if (hit(bus_req.addr, `ITSF_STAT1_OFF))
			rd_data_next = stat1_word;
	end
	always_ff @(posedge ref_clk)
	begin
		if (srst)
			rd_data_reg <= 32'h0000_0000;
		else if (ce && bus_req.rd)
			rd_data_reg <= rd_data_next;
	end

	assign rd_data = rd_data_reg;
	assign tx_byte = tx_data_reg;
	assign stretch_hold = byte_done_flag;
	assign peripheral_enable = en;
	sequence s_stat0_read;
		rd_s0;
	endsequence
	sequence s_armed_stat1_read;
		stat0_seen_reg && rd_s1 && !bus_ev.addr_match && !bus_ev.addr_acked;
	endsequence
	a_seq_arm: assert property (s_stat0_read |=> stat0_seen_reg)
		else $error("status0 read not remembered");
	a_rx_full_set: assert property (
		(ce && en && bus_ev.rx_valid && !rx_buffer_full) |=> rx_buffer_full &&
			rx_data_reg == $past(bus_ev.rx_byte))
		else $error("rx full not set on byte move");
	a_rx_full_hold: assert property (
		(rd_dat && rx_buffer_full && rx_pend_reg && en && !bus_ev.rx_valid)
			|=> rx_buffer_full && !rx_pend_reg)
		else $error("rx full dropped while byte waited");
	a_stop_clear: assert property (
		(stat0_seen_reg && wr_ctl0 && !bus_ev.stop_seen) |=> !stop_seen_flag)
		else $error("stop flag not cleared by sequence");
	a_btc_hw_clear: assert property (
		(ce && hw_clr && !(bus_ev.rx_valid || bus_ev.tx_sent)) |=> !byte_done_flag)
		else $error("byte done survived start, stop or disable");
	a_addr_clear: assert property (s_armed_stat1_read |=> !address_flag)
		else $error("address flag not cleared by status reads");
	a_pec_view: assert property (
		(ce && bus_req.rd && hit(bus_req.addr, `ITSF_STAT1_OFF) && pec_en)
			|=> rd_data[15:8] == $past(bus_ev.check_byte))
		else $error("check byte missing from status 1");
	a_busy_clear: assert property (
		(ce && bus_ev.stop_seen && !bus_ev.start_seen && !bus_ev.start_sent)
			|=> !bus_busy_flag)
		else $error("busy kept after stop");
	a_master_set: assert property (
		(ce && bus_ev.start_sent && en) |=> controller_flag && start_sent_flag)
		else $error("controller role not taken on start");
	a_tbe_set: assert property (
		(ce && bus_ev.tx_take) |=> tx_buffer_empty ##1 (tx_buffer_empty || $past(wr_dat)))
		else $error("tx empty not set on byte move");
endmodule // itsf_status
`default_nettype wire

// ==== inc/itsf_pkg.sv ====
package itsf_pkg;

	// register port request, one cycle per access
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} itsf_bus_req_t;

	// one-cycle events and levels from the bus engine, same clock
	typedef struct packed {
		logic start_sent;
		logic stop_sent;
		logic start_seen;
		logic stop_seen;
		logic header10_sent;
		logic addr_acked;
		logic addr_match;
		logic match_second;
		logic host_header;
		logic default_addr;
		logic general_call;
		logic arb_lost;
		logic dir_update;
		logic dir_tx;
		logic rx_valid;
		logic [7:0] rx_byte;
		logic tx_take;
		logic tx_sent;
		logic [7:0] check_byte;
	} itsf_event_t;

endpackage

// ==== inc/itsf_regs.svh ====
`ifndef ITSF_REGS_SVH
`define ITSF_REGS_SVH

// register offsets (byte addresses)
`define ITSF_CTL0_OFF 8'h00
`define ITSF_DATA_OFF 8'h10
`define ITSF_STAT0_OFF 8'h14
`define ITSF_STAT1_OFF 8'h18

// control_reg_0 fields
`define ITSF_CTL0_EN 0
`define ITSF_CTL0_PECEN 1
`define ITSF_CTL0_STRETCH 2
`define ITSF_CTL0_DUALEN 3
`define ITSF_CTL0_W 4
`define ITSF_CTL0_RST 4'h4

// transfer_status_0 fields
`define ITSF_S0_START 0
`define ITSF_S0_ADDR 1
`define ITSF_S0_BTC 2
`define ITSF_S0_H10 3
`define ITSF_S0_STOP 4
`define ITSF_S0_RXFULL 6
`define ITSF_S0_TXEMPTY 7

// transfer_status_1 fields
`define ITSF_S1_MASTER 0
`define ITSF_S1_BUSY 1
`define ITSF_S1_TX 2
`define ITSF_S1_GC 4
`define ITSF_S1_DEF 5
`define ITSF_S1_HOST 6
`define ITSF_S1_DUAL 7
`define ITSF_S1_PEC_LSB 8
`define ITSF_S1_PEC_MSB 15

// reset values
`define ITSF_STAT0_RST 32'h0000_0000
`define ITSF_STAT1_RST 32'h0000_0000

`endif

// ==== tb/itsf_engine_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// stand-in for the bus engine: a command index becomes a one-cycle event pulse
module itsf_engine_model (
	// clock
	input wire logic ref_clk,
	// command from the bench
	input wire logic [3:0] cmd,
	input wire logic qual,
	input wire logic [7:0] data,
	input wire logic [7:0] chk,
	// events to the block
	output var itsf_pkg::itsf_event_t bus_ev
);
	logic [15:0] p_reg;
	logic q_reg;
	logic [7:0] d_reg;

	always_ff @(posedge ref_clk)
	begin
		p_reg <= 16'h0001 << cmd;
		q_reg <= qual;
		// byte lane carries junk outside a valid pulse, so stale data is never trusted
		d_reg <= (cmd == 4'hd) ? data : ~data;
	end

	assign bus_ev = {p_reg[1], p_reg[2], p_reg[3], p_reg[4], p_reg[5], p_reg[6], p_reg[7],
		q_reg, p_reg[8], p_reg[9], p_reg[10], p_reg[11], p_reg[12], q_reg, p_reg[13],
		d_reg, p_reg[14], p_reg[15], chk};
endmodule // itsf_engine_model
`default_nettype wire

// ==== tb/itsf_status_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "itsf_regs.svh"
module itsf_status_tb;
	localparam logic [7:0] C0 = `ITSF_CTL0_OFF;
	localparam logic [7:0] DT = `ITSF_DATA_OFF;
	localparam logic [7:0] S0 = `ITSF_STAT0_OFF;
	localparam logic [7:0] S1 = `ITSF_STAT1_OFF;
	logic ref_clk;
	logic srst;
	logic ce;
	itsf_pkg::itsf_bus_req_t bus_req;
	itsf_pkg::itsf_event_t bus_ev;
	logic [31:0] rd_data;
	logic [7:0] tx_byte;
	logic tx_buffer_empty;
	logic stretch_hold;
	logic peripheral_enable;
	logic [3:0] cmd;
	logic qual;
	logic [7:0] data;
	logic [7:0] chk;
	logic rd_pend;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [3:0] cz[4] = '{4'h1, 4'hb, 4'h0, 4'h4};
	logic [7:0] post[4] = '{8'h01, 8'hf0, 8'h00, 8'h00};
	int n_errors = 0;
	int n_checks = 0;
	int cyc = 0;

	itsf_status dut (.ref_clk, .srst, .ce, .bus_req, .rd_data, .bus_ev, .tx_byte,
		.tx_buffer_empty, .stretch_hold, .peripheral_enable);
	itsf_engine_model eng (.ref_clk, .cmd, .qual, .data, .chk, .bus_ev);

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		acc(1'b1, 1'b0, a, d);
	endtask

	// expectation is noted before the strobe goes out
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		acc(1'b0, 1'b1, a, 32'h0);
	endtask

	// flag is settled one edge after the command edge
	task automatic ev(input logic [3:0] c, input logic q, input logic [7:0] d);
		bus_req <= '0;
		cmd <= c;
		qual <= q;
		data <= d;
		@(posedge ref_clk);
		cmd <= 4'h0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic fin(input string s);
		bus_req <= '0;
		repeat (3) @(posedge ref_clk);
		$display("test %s done", s);
	endtask

	always @(posedge ref_clk)
	begin
		rd_pend <= bus_req.rd & ce & ~srst;
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			give_verdict;
		end
	end

	// read data stand from the cycle after the strobe until the next read
	always @(negedge ref_clk)
		if (rd_pend === 1'b1)
			check(rd_data & msk_q.pop_front(), exp_q.pop_front());

	initial
	begin
		srst = 1'b1;
		ce = 1'b1;
		bus_req = '0;
		cmd = 4'h0;
		qual = 1'b0;
		data = 8'h00;
		void'($urandom(66183));
		chk = 8'($urandom);
		b1 = 8'($urandom);
		b2 = 8'($urandom);
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		rd(C0, `ITSF_CTL0_RST, 32'hf);
		rd(S0, `ITSF_STAT0_RST, '1);
		rd(S1, `ITSF_STAT1_RST, '1);
		rd(8'h04, 32'h0, '1);
		fin("reset");
		check(peripheral_enable, 32'h0);
		wr(C0, 32'h5);
		ce <= 1'b0;
		wr(C0, 32'h0);
		ce <= 1'b1;
		rd(C0, 32'h5, 32'hf);
		fin("enable");
		check(peripheral_enable, 32'h1);
		ev(4'h1, 1'b0, 8'h00);
		rd(S0, 32'h1, 32'h1f);
		rd(S1, 32'h3, 32'hff);
		rd(S0, 32'h1, 32'h1f);
		wr(DT, 32'h0);
		rd(S0, 32'h0, 32'h1f);
		ev(4'h5, 1'b0, 8'h00);
		rd(S0, 32'h8, 32'h1f);
		wr(DT, 32'h0);
		rd(S0, 32'h0, 32'h1f);
		ev(4'h6, 1'b0, 8'h00);
		wr(C0, 32'h5);
		rd(S1, 32'h3, 32'hff);
		rd(S0, 32'h2, 32'h1f);
		rd(S1, 32'h3, 32'hff);
		rd(S0, 32'h0, 32'h1f);
		ev(4'h2, 1'b0, 8'h00);
		rd(S1, 32'h0, 32'hff);
		fin("controller");
		ev(4'hd, 1'b0, b1);
		rd(S0, 32'h40, 32'h5f);
		rd(DT, {24'h0, b1}, 32'hff);
		rd(S0, 32'h0, 32'h5f);
		ev(4'hd, 1'b0, b1);
		ev(4'hd, 1'b0, b2);
		check(stretch_hold, 32'h1);
		rd(S0, 32'h44, 32'h5f);
		rd(DT, {24'h0, b1}, 32'hff);
		rd(S0, 32'h40, 32'h5f);
		rd(DT, {24'h0, b2}, 32'hff);
		rd(S0, 32'h0, 32'h5f);
		for (int i = 0; i < 3; i++)
		begin
			ev(4'hd, 1'b0, b1);
			ev(4'hd, 1'b0, b2);
			if (i < 2)
				ev(4'(i + 1), 1'b0, 8'h00);
			else
			begin
				// disable clears the flag one edge after the write lands
				wr(C0, 32'h4);
				acc(1'b0, 1'b0, C0, 32'h0);
			end
			rd(S0, 32'h0, 32'h4);
			rd(DT, 32'h0, 32'h0);
			rd(DT, 32'h0, 32'h0);
			wr(C0, 32'h5);
		end
		fin("receive");
		wr(C0, 32'hd);
		for (int i = 0; i < 4; i++)
		begin
			// lost arbitration first, so the flags below arrive as target
			ev(4'hb, 1'b0, 8'h00);
			ev(4'h7, i[0], 8'h00);
			ev(4'h8, 1'b0, 8'h00);
			ev(4'h9, 1'b0, 8'h00);
			ev(4'ha, 1'b0, 8'h00);
			ev(4'hc, 1'b1, 8'h00);
			rd(S1, {24'h0, i[0], 7'h74}, 32'hfc);
			if (cz[i] != 4'h0)
				ev(cz[i], 1'b0, 8'h00);
			else
			begin
				wr(C0, 32'hc);
				acc(1'b0, 1'b0, C0, 32'h0);
			end
			rd(S1, {24'h0, post[i]}, 32'hfd);
			wr(C0, 32'hd);
		end
		rd(S0, 32'h10, 32'h10);
		wr(DT, 32'h0);
		rd(S0, 32'h10, 32'h10);
		wr(C0, 32'hd);
		rd(S0, 32'h0, 32'h10);
		fin("status1");
		wr(C0, 32'hf);
		rd(S1, {16'h0, chk, 8'h00}, 32'hff00);
		wr(C0, 32'hd);
		rd(S1, 32'h0, 32'hff00);
		wr(DT, {24'h0, b1});
		fin("check byte");
		check(tx_byte, {24'h0, b1});
		ev(4'he, 1'b0, 8'h00);
		check(tx_buffer_empty, 32'h1);
		ev(4'hc, 1'b1, 8'h00);
		ev(4'hf, 1'b0, 8'h00);
		check(stretch_hold, 32'h1);
		rd(S0, 32'h84, 32'h84);
		wr(DT, {24'h0, b2});
		fin("transmit");
		check(tx_buffer_empty, 32'h0);
		check(stretch_hold, 32'h0);
		give_verdict;
	end
endmodule // itsf_status_tb
`default_nettype wire
